// file: pbg_map.vh
// Register offsets, field positions and reset values of the port B block.
`ifndef PBG_MAP_VH
`define PBG_MAP_VH
// Register indices; each register is one aligned word at four times its index.
`define PBG_IDX_DATA 8'h06
`define PBG_IDX_DIR 8'h86
`define PBG_IDX_OPTION 8'h81
`define PBG_IDX_INTCTL 8'h0B
`define PBG_IDX_IRQ_STAT 8'hA0
`define PBG_IDX_IRQ_MASK 8'hA4
`define PBG_IDX_MODE 8'hA8
`define PBG_OFF_DATA {`PBG_IDX_DATA, 2'b00}
`define PBG_OFF_DIR {`PBG_IDX_DIR, 2'b00}
`define PBG_OFF_OPTION {`PBG_IDX_OPTION, 2'b00}
`define PBG_OFF_INTCTL {`PBG_IDX_INTCTL, 2'b00}
`define PBG_OFF_IRQ_STAT {`PBG_IDX_IRQ_STAT, 2'b00}
`define PBG_OFF_IRQ_MASK {`PBG_IDX_IRQ_MASK, 2'b00}
`define PBG_OFF_MODE {`PBG_IDX_MODE, 2'b00}
`define PBG_SETTLE_CYC 2'h3
`define PBG_BIT_PULLUP_DIS 7
`define PBG_BIT_CHANGE_IE 3
`define PBG_BIT_EXT_IE 4
`define PBG_BIT_EXT_EDGE 6
`define PBG_BIT_EXT_FLAG 1
`define PBG_BIT_CHANGE_FLAG 0
`define PBG_BIT_PROG_MODE 0
`define PBG_BIT_SLEEP 1
`define PBG_RST_DIR 8'hFF
`define PBG_RST_OPTION 8'hFF
`define PBG_RST_ZERO 8'h00
`define PBG_RESP_OKAY 2'b00
`define PBG_RESP_SLVERR 2'b10
`define PBG_CHG_LSB 4
`define PBG_CHG_MSB 7
`define PBG_PIN_EXT 0
`define PBG_PIN_PCLK 6
`define PBG_PIN_PDAT 7
`endif

// file: pbg_sync.v
// Two-flop synchroniser for a bus of asynchronous pin inputs.
module pbg_sync #(
  parameter WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_r;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// file: pbg_port.v
// Eight-bit general-purpose port B with pull-ups, pin-change detect and AXI4-Lite registers.
`include "pbg_map.vh"

// Notes on behaviour
// - Eight bidirectional pins; a set direction bit makes the pin an input, a clear one drives the latch.
// - One active-low pull-up disable bit at option bit 7 turns on the pull-ups of all pins set as inputs when clear.
// - A pin set as an output never has its pull-up on, whatever the global enable.
// - After power-on reset all pull-ups are off.
// - Only pins 7 to 4 set as inputs take part in change detection.
// - Each taking part pin is compared with the value latched at the last port read or write; any mismatch sets bit 0 of interrupt control.
// - An enabled pin-change interrupt raises the wake request out of sleep.
// - Any read, or any write with strobe bit 0 set, of the port data register reloads the compare latch with the current pins.
// - A persisting mismatch keeps setting the flag, so software reads the port first, then clears it.
// - Pin 0 is also the external interrupt input, with a Schmitt buffer selected while that use is enabled.
// - Pins 6 and 7 are programming clock and data, with Schmitt buffers while programming mode is on.
module pbg_port #(
  parameter ADDR_WIDTH = 10
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] port_b_in,
  output reg [7:0] port_b_out,
  output reg [7:0] port_b_oe_n,
  output reg [7:0] pullup_en,
  output reg [7:0] schmitt_en,
  output reg prog_clock_pin,
  output reg prog_data_pin,
  output reg ext_interrupt_pin,
  output reg wake_req,
  output wire irq
);
  reg [7:0] port_b_data_reg_r;
  reg [7:0] port_b_direction_reg_r;
  reg [7:0] option_r;
  reg [7:0] interrupt_control_reg_r;
  reg [7:0] compare_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg [1:0] mode_r;
  reg [ADDR_WIDTH-1:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg aw_full_r;
  reg w_full_r;
  reg ext_prev_r;
  wire [7:0] pins_s;
  wire wr_go;
  wire rd_go;
  wire wr_data_hit;
  wire rd_data_hit;
  wire [3:0] chg_mask;
  wire mismatch;
  wire ext_edge;
  reg [31:0] rd_val;
  reg rd_ok;
  reg wr_ok;
  reg [7:0] ic_nxt;
  reg [7:0] schmitt_nxt;
  reg [1:0] settle_r;
  wire [7:0] pullup_nxt;
  wire [3:0] pin_mismatch;
  wire ext_rise;
  wire ext_fall;
  wire ext_settled;
  wire wr_lo;
  wire stat_rd_hit;
  wire wake_nxt;
  genvar gi;

  // No logic reads the raw pins; everything below sees the synchronised copy.
  pbg_sync #(
    .WIDTH(8)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(port_b_in),
    .sync_out(pins_s)
  );

  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_data_hit = wr_go && (awaddr_r == `PBG_OFF_DATA) && wstrb_r[0];
  assign rd_data_hit = rd_go && (s_axi_araddr == `PBG_OFF_DATA);
  assign wr_lo = wr_go && wstrb_r[0];
  assign stat_rd_hit = rd_go && (s_axi_araddr == `PBG_OFF_IRQ_STAT);

  // Outputs are excluded from comparison by masking with the direction bits.
  assign chg_mask = port_b_direction_reg_r[`PBG_CHG_MSB:`PBG_CHG_LSB];
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_chg
      assign pin_mismatch[gi] = chg_mask[gi]
        && (pins_s[`PBG_CHG_LSB + gi] != compare_r[`PBG_CHG_LSB + gi]);
    end
  endgenerate

  // The per-pin mismatch results are ORed into one condition.
  assign mismatch = |pin_mismatch;

  // Edges are ignored until the synchroniser and the previous-value flop hold real pin data.
  assign ext_settled = (settle_r == `PBG_SETTLE_CYC);
  assign ext_rise = pins_s[`PBG_PIN_EXT] && !ext_prev_r;
  assign ext_fall = !pins_s[`PBG_PIN_EXT] && ext_prev_r;
  assign ext_edge = ext_settled && (option_r[`PBG_BIT_EXT_EDGE] ? ext_rise : ext_fall);

  // A pin's pull-up needs the global enable and an input direction.
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pull
      assign pullup_nxt[gi] = !option_r[`PBG_BIT_PULLUP_DIS]
        && port_b_direction_reg_r[gi];
    end
  endgenerate

  // Only pins with a special input use get the Schmitt buffer.
  always @*
  begin
    schmitt_nxt = 8'h00;
    schmitt_nxt[`PBG_PIN_EXT] = interrupt_control_reg_r[`PBG_BIT_EXT_IE];
    schmitt_nxt[`PBG_PIN_PCLK] = mode_r[`PBG_BIT_PROG_MODE];
    schmitt_nxt[`PBG_PIN_PDAT] = mode_r[`PBG_BIT_PROG_MODE];
  end

  assign wake_nxt = mode_r[`PBG_BIT_SLEEP] && interrupt_control_reg_r[`PBG_BIT_CHANGE_FLAG]
    && interrupt_control_reg_r[`PBG_BIT_CHANGE_IE];
  assign irq = |(irq_stat_r & irq_mask_r);

  always @*
  begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `PBG_OFF_DATA: rd_val[7:0] = pins_s;
      `PBG_OFF_DIR: rd_val[7:0] = port_b_direction_reg_r;
      `PBG_OFF_OPTION: rd_val[7:0] = option_r;
      `PBG_OFF_INTCTL: rd_val[7:0] = interrupt_control_reg_r;
      `PBG_OFF_IRQ_STAT: rd_val[1:0] = irq_stat_r;
      `PBG_OFF_IRQ_MASK: rd_val[1:0] = irq_mask_r;
      `PBG_OFF_MODE: rd_val[1:0] = mode_r;
      default: rd_ok = 1'b0;
    endcase
  end

  always @*
  begin
    case (awaddr_r)
      `PBG_OFF_DATA: wr_ok = 1'b1;
      `PBG_OFF_DIR: wr_ok = 1'b1;
      `PBG_OFF_OPTION: wr_ok = 1'b1;
      `PBG_OFF_INTCTL: wr_ok = 1'b1;
      `PBG_OFF_IRQ_STAT: wr_ok = 1'b1;
      `PBG_OFF_IRQ_MASK: wr_ok = 1'b1;
      `PBG_OFF_MODE: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Software writes land first, then hardware events are ORed in so a set wins.
  always @*
  begin
    ic_nxt = interrupt_control_reg_r;
    if (wr_lo && (awaddr_r == `PBG_OFF_INTCTL))
      ic_nxt = wdata_r[7:0];
    if (mismatch)
      ic_nxt[`PBG_BIT_CHANGE_FLAG] = 1'b1;
    if (ext_edge)
      ic_nxt[`PBG_BIT_EXT_FLAG] = 1'b1;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_b_data_reg_r <= `PBG_RST_ZERO;
      port_b_direction_reg_r <= `PBG_RST_DIR;
      option_r <= `PBG_RST_OPTION;
      interrupt_control_reg_r <= `PBG_RST_ZERO;
      compare_r <= `PBG_RST_ZERO;
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
      mode_r <= 2'b00;
      awaddr_r <= {ADDR_WIDTH{1'b0}};
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PBG_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `PBG_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      ext_prev_r <= 1'b0;
      settle_r <= 2'h0;
    end
    else
    begin
      ext_prev_r <= pins_s[`PBG_PIN_EXT];
      if (!ext_settled)
        settle_r <= settle_r + 2'h1;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
      end
      if (wr_go)
      begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `PBG_RESP_OKAY : `PBG_RESP_SLVERR;
        if (wstrb_r[0])
        begin
          case (awaddr_r)
            `PBG_OFF_DATA: port_b_data_reg_r <= wdata_r[7:0];
            `PBG_OFF_DIR: port_b_direction_reg_r <= wdata_r[7:0];
            `PBG_OFF_OPTION: option_r <= wdata_r[7:0];
            `PBG_OFF_IRQ_MASK: irq_mask_r <= wdata_r[1:0];
            `PBG_OFF_MODE: mode_r <= wdata_r[1:0];
            default: mode_r <= mode_r;
          endcase
        end
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_data_hit || wr_data_hit)
        compare_r <= pins_s;
      interrupt_control_reg_r <= ic_nxt;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? `PBG_RESP_OKAY : `PBG_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      // Sticky status: read clears, but a new event in the same cycle stays set.
      if (stat_rd_hit)
        irq_stat_r <= {ext_edge, mismatch};
      else
        irq_stat_r <= irq_stat_r | {ext_edge, mismatch};
    end
  end

  // Pin drive, pull-ups, buffer selection and wake request.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_b_out <= 8'h00;
      port_b_oe_n <= 8'hFF;
      pullup_en <= 8'h00;
      schmitt_en <= 8'h00;
      prog_clock_pin <= 1'b0;
      prog_data_pin <= 1'b0;
      ext_interrupt_pin <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      port_b_out <= port_b_data_reg_r;
      port_b_oe_n <= port_b_direction_reg_r;
      pullup_en <= pullup_nxt;
      schmitt_en <= schmitt_nxt;
      prog_clock_pin <= pins_s[`PBG_PIN_PCLK] & mode_r[`PBG_BIT_PROG_MODE];
      prog_data_pin <= pins_s[`PBG_PIN_PDAT] & mode_r[`PBG_BIT_PROG_MODE];
      ext_interrupt_pin <= pins_s[`PBG_PIN_EXT];
      wake_req <= wake_nxt;
    end
  end
endmodule

// file: pbg_port_chk.sv
// Port-level assertions for the port B block.
module pbg_port_chk(
  input aclk,
  input aresetn,
  input s_axi_awvalid,
  input s_axi_awready,
  input s_axi_wvalid,
  input s_axi_wready,
  input s_axi_bvalid,
  input s_axi_bready,
  input s_axi_arvalid,
  input s_axi_arready,
  input s_axi_rvalid,
  input s_axi_rready,
  input [31:0] s_axi_rdata,
  input [7:0] port_b_in,
  input [7:0] port_b_oe_n,
  input [7:0] pullup_en,
  input [7:0] schmitt_en,
  input prog_clock_pin,
  input ext_interrupt_pin,
  input wake_req,
  input irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] up_r;
  always @(posedge aclk)
    up_r <= !aresetn ? 2'h0 : up_r + {1'b0, up_r != 2'h3};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_pullup_out_off: assert property ((pullup_en & ~port_b_oe_n & ~$past(port_b_oe_n)) == 8'h00)
    else $error("pull-up on at an output pin");
  a_pullup_common: assert property ((pullup_en & port_b_oe_n & $past(port_b_oe_n)) == 8'h00
    || (pullup_en & port_b_oe_n & $past(port_b_oe_n)) == (port_b_oe_n & $past(port_b_oe_n)))
    else $error("input pull-ups differ");
  a_reset_state: assert property (@(posedge aclk) disable iff (1'b0)
    !aresetn |=> pullup_en == 8'h00 && port_b_oe_n == 8'hFF && !irq)
    else $error("state after reset wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_ext_follow: assert property (up_r == 2'h3 |-> ext_interrupt_pin == $past(port_b_in[0], 3))
    else $error("interrupt pin does not follow");
  a_prog_gated: assert property (!schmitt_en[6] && !$past(schmitt_en[6]) |-> !prog_clock_pin)
    else $error("programming clock outside mode");
  cover property (irq);
  cover property (wake_req);
  cover property (prog_clock_pin);
endmodule

bind pbg_port pbg_port_chk u_chk(.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .port_b_in, .port_b_oe_n, .pullup_en, .schmitt_en,
  .prog_clock_pin, .ext_interrupt_pin, .wake_req, .irq);

// file: pbg_keypad.sv
// Model of the pins outside the port: keypad switches, pull-ups and floating lines.
module pbg_keypad(
  input aclk,
  input [7:0] port_b_out,
  input [7:0] port_b_oe_n,
  input [7:0] pullup_en,
  input [7:0] key_n,
  output logic [7:0] port_b_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] flt_r = 8'h00;
  always @(posedge aclk)
    flt_r <= ~flt_r;
  // An undriven line without pull-up shows a level that changes every cycle.
  always_comb
    for (int i = 0; i < 8; i++)
      port_b_in[i] = !port_b_oe_n[i] ? port_b_out[i] : !key_n[i] ? 1'b0 : pullup_en[i] | flt_r[i];
endmodule

// file: pbg_port_test.sv
// Self-checking bench for the port B block.
`include "pbg_map.vh"
module pbg_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [7:0] key_n = 8'hFF;
  logic [31:0] s_axi_wdata = 32'h0, rv;
  logic [1:0] rs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire prog_clock_pin, prog_data_pin, ext_interrupt_pin, wake_req, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] port_b_in, port_b_out, port_b_oe_n, pullup_en, schmitt_en;
  int n_fail = 0, checked = 0;
  always #25 aclk = ~aclk;
  pbg_port dut(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_b_in, .port_b_out, .port_b_oe_n, .pullup_en, .schmitt_en,
    .prog_clock_pin, .prog_data_pin, .ext_interrupt_pin, .wake_req, .irq);
  pbg_keypad pad(.aclk, .port_b_out, .port_b_oe_n, .pullup_en, .key_n, .port_b_in);
  task chk(input [31:0] got, input [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_resp(input [1:0] got, input [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask
  task wr(input [9:0] a, input [31:0] d, output [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [9:0] a, output [31:0] d, output [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task w(input [9:0] a, input [7:0] d);
    wr(a, {24'h0, d}, rs);
    chk_resp(rs, `PBG_RESP_OKAY);
  endtask
  task rc(input [9:0] a, input [7:0] e);
    rd(a, rv, rs);
    chk(rv, {24'h0, e});
    chk_resp(rs, `PBG_RESP_OKAY);
  endtask
  task print_verdict;
    $display("mismatches %0d comparisons %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #500000;
    n_fail++;
    print_verdict();
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk(pullup_en, 8'h00);
    w(`PBG_OFF_DATA, 8'h5A);
    repeat (3) @(posedge aclk);
    chk(port_b_out, 8'h5A);
    w(`PBG_OFF_OPTION, 8'h7F);
    w(`PBG_OFF_DIR, 8'hF0);
    repeat (3) @(posedge aclk);
    chk(port_b_oe_n, 8'hF0);
    chk(pullup_en, 8'hF0);
    rc(`PBG_OFF_DATA, 8'hFA);
    w(`PBG_OFF_INTCTL, 8'h08);
    w(`PBG_OFF_IRQ_MASK, 8'h01);
    rd(`PBG_OFF_IRQ_STAT, rv, rs);
    rc(`PBG_OFF_INTCTL, 8'h08);
    w(`PBG_OFF_DIR, 8'h70);
    repeat (6) @(posedge aclk);
    rc(`PBG_OFF_INTCTL, 8'h08);
    key_n <= 8'hDF;
    repeat (6) @(posedge aclk);
    chk(irq, 1'b1);
    rc(`PBG_OFF_INTCTL, 8'h09);
    w(`PBG_OFF_INTCTL, 8'h08);
    rc(`PBG_OFF_INTCTL, 8'h09);
    rc(`PBG_OFF_DATA, 8'h5A);
    w(`PBG_OFF_INTCTL, 8'h08);
    rc(`PBG_OFF_INTCTL, 8'h08);
    rc(`PBG_OFF_IRQ_STAT, 8'h01);
    rc(`PBG_OFF_IRQ_STAT, 8'h00);
    chk(irq, 1'b0);
    w(`PBG_OFF_MODE, 8'h02);
    key_n <= 8'hFF;
    repeat (6) @(posedge aclk);
    chk(wake_req, 1'b1);
    w(`PBG_OFF_IRQ_MASK, 8'h00);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    w(`PBG_OFF_INTCTL, 8'h10);
    w(`PBG_OFF_MODE, 8'h01);
    repeat (4) @(posedge aclk);
    chk(schmitt_en, 8'hC1);
    chk(prog_clock_pin, 1'b1);
    chk(prog_data_pin, 1'b0);
    wr(10'h100, 32'h5, rs);
    chk_resp(rs, `PBG_RESP_SLVERR);
    rd(10'h100, rv, rs);
    chk(rv, 32'h0);
    chk_resp(rs, `PBG_RESP_SLVERR);
    w(`PBG_OFF_OPTION, 8'hFF);
    repeat (3) @(posedge aclk);
    chk(pullup_en, 8'h00);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(port_b_oe_n, 8'hFF);
    print_verdict();
  end
endmodule
